// ### design/power_sequence_manager.sv
// power sequence manager: sequencer, channel classifier, flags and apb registers
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module power_sequence_manager #(
    parameter int NUM_CH = 22,
    parameter int MAX_CH = 32,
    parameter int DEBOUNCE_CYC = psm_pkg::DEBOUNCE_CYC,
    parameter int STEP_TIMEOUT_CYC = psm_pkg::STEP_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sequence_toggle_button,
    input wire logic [31:0] gp_inputs,
    input wire logic [NUM_CH*12-1:0] ch_voltage,
    input wire psm_pkg::ch_thr_s [NUM_CH-1:0] ch_thr,
    output logic [31:0] regulator_enables,
    output logic [31:0] output_flags,
    output logic open_loop_trim_en,
    output logic closed_loop_trim_en,
    output logic monitor_en,
    output logic [31:0] cfg_fetch_addr,
    output logic [31:0] prog_fetch_addr,
    output logic irq
);
    localparam int NCH_EFF = (NUM_CH < MAX_CH) ? NUM_CH : MAX_CH;
    localparam int IDX_W = $clog2(NUM_CH + 1);
    localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
    localparam int TO_W = $clog2(STEP_TIMEOUT_CYC + 1);

    psm_pkg::op_state_e state_q;
    logic [IDX_W-1:0] step_q;
    logic [TO_W-1:0] step_cnt_q;
    logic [31:0] reg_en_q;
    logic [31:0] flags_q;
    logic [31:0] flag_sel_q;
    logic [31:0] cfg_base_q;
    logic [31:0] ch_en_q;
    logic [4:0] ch_sel_q;
    logic [psm_pkg::IRQ_W-1:0] irq_stat_q;
    logic [psm_pkg::IRQ_W-1:0] irq_mask_q;
    logic [1:0] btn_sync_q;
    logic btn_stable_q;
    logic [DB_W-1:0] db_cnt_q;
    logic [31:0] gpi_s1_q;
    logic [31:0] gpi_q;
    logic [31:0] ch_valid;
    logic [31:0] ch_nominal;
    logic [31:0] ch_fault;
    logic [2:0] ch_class [NUM_CH];
    logic btn_press;
    logic wr_acc;
    logic start_req;
    logic stop_req;
    logic step_ok;
    logic step_timeout;
    localparam int IRQ_W_FIX = psm_pkg::IRQ_W;
    logic [IRQ_W_FIX-1:0] irq_set;

    // thresholds with hysteresis added must not exceed range top; hysteresis above the level is bad too
    function automatic logic thr_bad(input logic [11:0] lvl, input logic [11:0] hy,
                                     input logic [11:0] top);
        logic [12:0] hi;
        hi = {1'b0, lvl} + {1'b0, hy};
        thr_bad = (hi > {1'b0, top}) || (hy > lvl);
    endfunction

    // classify channels and check validity against measurement range
    always_comb
    begin
        ch_valid = '0;
        ch_nominal = '0;
        ch_fault = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            logic [11:0] v;
            v = ch_voltage[i*12 +: 12];
            if (i < NCH_EFF)
            begin
                ch_valid[i] = !(thr_bad(ch_thr[i].uv2, ch_thr[i].hyst, ch_thr[i].range_max)
                    || thr_bad(ch_thr[i].uv1, ch_thr[i].hyst, ch_thr[i].range_max)
                    || thr_bad(ch_thr[i].ov1, ch_thr[i].hyst, ch_thr[i].range_max)
                    || thr_bad(ch_thr[i].ov2, ch_thr[i].hyst, ch_thr[i].range_max));
            end
            if (!ch_valid[i] || v < ch_thr[i].off_lvl)
                ch_class[i] = 3'(psm_pkg::CH_OFF);
            else if (v < ch_thr[i].uv2)
                ch_class[i] = 3'(psm_pkg::CH_UNDER_VOLTAGE_LEVEL_TWO);
            else if (v < ch_thr[i].uv1)
                ch_class[i] = 3'(psm_pkg::CH_UNDER_VOLTAGE_LEVEL_ONE);
            else if (v <= ch_thr[i].ov1)
                ch_class[i] = 3'(psm_pkg::CH_NOMINAL);
            else if (v <= ch_thr[i].ov2)
                ch_class[i] = 3'(psm_pkg::CH_OVER_VOLTAGE_LEVEL_ONE);
            else
                ch_class[i] = 3'(psm_pkg::CH_OVER_VOLTAGE_LEVEL_TWO);
            ch_nominal[i] = ch_class[i] == 3'(psm_pkg::CH_NOMINAL);
            ch_fault[i] = ch_valid[i] && monitor_en && reg_en_q[i] && !ch_nominal[i];
        end
    end

    // two-flop synchronisers on pins
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            btn_sync_q <= 2'h0;
            gpi_s1_q <= 32'h0;
            gpi_q <= 32'h0;
        end
        else
        begin
            btn_sync_q <= {btn_sync_q[0], sequence_toggle_button};
            gpi_s1_q <= gp_inputs;
            gpi_q <= gpi_s1_q;
        end
    end

    // debounce: level must hold for the full count before it is believed
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            btn_stable_q <= 1'b0;
            db_cnt_q <= '0;
        end
        else if (btn_sync_q[1] == btn_stable_q)
            db_cnt_q <= '0;
        else if (db_cnt_q == DB_W'(DEBOUNCE_CYC - 1))
        begin
            btn_stable_q <= btn_sync_q[1];
            db_cnt_q <= '0;
        end
        else
            db_cnt_q <= db_cnt_q + 1'b1;
    end

    assign btn_press = (btn_sync_q[1] && !btn_stable_q && db_cnt_q == DB_W'(DEBOUNCE_CYC - 1));
    assign wr_acc = psel && penable && pwrite;
    // button alternates start and stop; each is gated by state
    assign start_req = (btn_press && state_q == psm_pkg::ST_IDLE)
        || (wr_acc && paddr == psm_pkg::CTRL_OFF && pwdata[psm_pkg::CTRL_START_BIT]
            && state_q == psm_pkg::ST_IDLE);
    assign stop_req = (btn_press && state_q == psm_pkg::ST_RUNNING)
        || (wr_acc && paddr == psm_pkg::CTRL_OFF && pwdata[psm_pkg::CTRL_STOP_BIT]
            && state_q == psm_pkg::ST_RUNNING);

    // a step is satisfied when the channel qualifies or takes no part
    assign step_ok = (32'(step_q) >= 32'(NCH_EFF)) || !ch_en_q[step_q] || !ch_valid[step_q]
        || (state_q == psm_pkg::ST_POWER_UP ? ch_nominal[step_q]
            : ch_class[step_q] == 3'(psm_pkg::CH_OFF));
    assign step_timeout = step_cnt_q == TO_W'(STEP_TIMEOUT_CYC - 1);

    // operating state machine and ordered enable sequencing
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_q <= psm_pkg::ST_IDLE;
            step_q <= '0;
            step_cnt_q <= '0;
            reg_en_q <= 32'h0;
        end
        else
        begin
            unique case (state_q)
                psm_pkg::ST_IDLE:
                    if (start_req)
                    begin
                        state_q <= psm_pkg::ST_POWER_UP;
                        step_q <= '0;
                        step_cnt_q <= '0;
                    end
                psm_pkg::ST_POWER_UP:
                begin
                    if (32'(step_q) < 32'(NCH_EFF) && ch_en_q[step_q])
                        reg_en_q[step_q] <= 1'b1;
                    if (32'(step_q) >= 32'(NCH_EFF))
                        state_q <= psm_pkg::ST_RUNNING;
                    else if (step_cnt_q != '0 && step_ok)
                    begin
                        step_q <= step_q + 1'b1;
                        step_cnt_q <= '0;
                    end
                    // only channels already qualified count; the one ramping is still settling
                    else if (step_timeout
                             || (ch_fault & ~(32'hffffffff << step_q)) != 32'h0)
                    begin
                        reg_en_q <= 32'h0;
                        step_q <= '0;
                        step_cnt_q <= '0;
                    end
                    else
                        step_cnt_q <= step_cnt_q + 1'b1;
                end
                psm_pkg::ST_RUNNING:
                    if (stop_req)
                    begin
                        state_q <= psm_pkg::ST_POWER_DOWN;
                        step_q <= '0;
                        step_cnt_q <= '0;
                    end
                psm_pkg::ST_POWER_DOWN:
                begin
                    if (32'(step_q) < 32'(NCH_EFF))
                        reg_en_q[step_q] <= 1'b0;
                    if (32'(step_q) >= 32'(NCH_EFF))
                        state_q <= psm_pkg::ST_IDLE;
                    else if ((step_cnt_q != '0 && step_ok) || step_timeout)
                    begin
                        step_q <= step_q + 1'b1;
                        step_cnt_q <= '0;
                    end
                    else
                        step_cnt_q <= step_cnt_q + 1'b1;
                end
            endcase
        end
    end

    // trim and monitor enables follow the operating state
    assign open_loop_trim_en = state_q == psm_pkg::ST_POWER_UP;
    assign closed_loop_trim_en = state_q == psm_pkg::ST_RUNNING;
    assign monitor_en = state_q != psm_pkg::ST_IDLE;
    assign regulator_enables = reg_en_q;
    assign output_flags = flags_q;
    assign cfg_fetch_addr = cfg_base_q;
    assign prog_fetch_addr = psm_pkg::PROG_BASE;

    // flags: nominal per channel, or a sampled input where selected; cleared when idle
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            flags_q <= 32'h0;
        else if (!monitor_en)
            flags_q <= 32'h0;
        else
            flags_q <= (ch_nominal & ~flag_sel_q) | (gpi_q & flag_sel_q);
    end

    // sticky events; a new event wins over a write-one clear
    assign irq_set[psm_pkg::IRQ_RUN_BIT] = state_q == psm_pkg::ST_POWER_UP
        && 32'(step_q) >= 32'(NCH_EFF);
    assign irq_set[psm_pkg::IRQ_IDLE_BIT] = state_q == psm_pkg::ST_POWER_DOWN
        && 32'(step_q) >= 32'(NCH_EFF);
    assign irq_set[psm_pkg::IRQ_RETRY_BIT] = state_q == psm_pkg::ST_POWER_UP
        && 32'(step_q) < 32'(NCH_EFF) && step_timeout && !(step_cnt_q != '0 && step_ok);
    assign irq_set[psm_pkg::IRQ_FAULT_BIT] = state_q == psm_pkg::ST_RUNNING && |ch_fault;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            irq_stat_q <= '0;
        else if (wr_acc && paddr == psm_pkg::IRQ_STAT_OFF)
            irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W_FIX-1:0]) | irq_set;
        else
            irq_stat_q <= irq_stat_q | irq_set;
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // software writable configuration
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            irq_mask_q <= '0;
            cfg_base_q <= psm_pkg::CFG_BASE_RST;
            ch_sel_q <= 5'h0;
            flag_sel_q <= psm_pkg::FLAG_SEL_RST;
            ch_en_q <= 32'hffffffff;
        end
        else if (wr_acc)
        begin
            unique case (paddr)
                psm_pkg::IRQ_MASK_OFF: irq_mask_q <= pwdata[IRQ_W_FIX-1:0];
                psm_pkg::CFG_BASE_OFF: cfg_base_q <= pwdata;
                psm_pkg::CH_SEL_OFF: ch_sel_q <= pwdata[4:0];
                psm_pkg::FLAG_SEL_OFF: flag_sel_q <= pwdata;
                psm_pkg::CH_EN_OFF: ch_en_q <= pwdata;
                default: ;
            endcase
        end
    end

    // apb answers in the access cycle with zero wait states
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // read mux: selected channel voltage and class in any state
    always_comb
    begin
        logic [4:0] s;
        s = ch_sel_q;
        prdata = 32'h0;
        if (psel && penable && !pwrite)
        begin
            unique case (paddr)
                psm_pkg::STATUS_OFF: prdata = {30'h0, state_q};
                psm_pkg::IRQ_STAT_OFF: prdata = {28'h0, irq_stat_q};
                psm_pkg::IRQ_MASK_OFF: prdata = {28'h0, irq_mask_q};
                psm_pkg::CFG_BASE_OFF: prdata = cfg_base_q;
                psm_pkg::CH_SEL_OFF: prdata = {27'h0, ch_sel_q};
                psm_pkg::CH_READ_OFF:
                    if (32'(s) < 32'(NCH_EFF) && ch_valid[s])
                        prdata = {13'h0, ch_class[s], 4'h0, ch_voltage[s*12 +: 12]};
                psm_pkg::FLAGS_OFF: prdata = flags_q;
                psm_pkg::INPUTS_OFF: prdata = gpi_q;
                psm_pkg::REG_EN_OFF: prdata = reg_en_q;
                psm_pkg::VALID_OFF: prdata = ch_valid;
                psm_pkg::FLAG_SEL_OFF: prdata = flag_sel_q;
                psm_pkg::CH_EN_OFF: prdata = ch_en_q;
                default: prdata = 32'h0;
            endcase
        end
    end

    // assertions
    property p_trim_closed;
        @(posedge clk_sys) disable iff (!nrst)
        closed_loop_trim_en |-> state_q == psm_pkg::ST_RUNNING && !open_loop_trim_en;
    endproperty
    a_trim_closed: assert property (p_trim_closed) else $error("closed trim outside run");

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (!nrst)
        state_q == psm_pkg::ST_IDLE && $past(state_q) == psm_pkg::ST_IDLE
            |-> flags_q == 32'h0 && !monitor_en;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle not quiet");

    property p_start_gate;
        @(posedge clk_sys) disable iff (!nrst)
        state_q == psm_pkg::ST_RUNNING |=> state_q != psm_pkg::ST_POWER_UP;
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("start from running");

    property p_down_order;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(state_q == psm_pkg::ST_POWER_DOWN) |-> !closed_loop_trim_en && monitor_en;
    endproperty
    a_down_order: assert property (p_down_order) else $error("power down order");

    property p_run_entry;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(state_q == psm_pkg::ST_RUNNING) |-> $past(state_q) == psm_pkg::ST_POWER_UP;
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("bad run entry");

    property p_up_active;
        @(posedge clk_sys) disable iff (!nrst)
        state_q == psm_pkg::ST_POWER_UP |-> open_loop_trim_en && monitor_en;
    endproperty
    a_up_active: assert property (p_up_active) else $error("power up not active");

    property p_idle_regs_off;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(state_q == psm_pkg::ST_IDLE) |-> reg_en_q[NCH_EFF-1:0] == '0;
    endproperty
    a_idle_regs_off: assert property (p_idle_regs_off) else $error("enables left on");

    property p_no_extra_en;
        @(posedge clk_sys) disable iff (!nrst)
        1'b1 |-> (reg_en_q & ~ch_en_q) == 32'h0 || state_q == psm_pkg::ST_POWER_DOWN;
    endproperty
    a_no_extra_en: assert property (p_no_extra_en) else $error("disabled channel on");

    property p_btn_toggle;
        @(posedge clk_sys) disable iff (!nrst)
        btn_press && state_q == psm_pkg::ST_IDLE |=> state_q == psm_pkg::ST_POWER_UP;
    endproperty
    a_btn_toggle: assert property (p_btn_toggle) else $error("button ignored");
endmodule

// ### include/psm_pkg.sv
// package: constants, types and register map of the power sequence manager
package psm_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
    localparam logic [7:0] CFG_BASE_OFF = 8'h10;
    localparam logic [7:0] CH_SEL_OFF = 8'h14;
    localparam logic [7:0] CH_READ_OFF = 8'h18;
    localparam logic [7:0] FLAGS_OFF = 8'h1c;
    localparam logic [7:0] INPUTS_OFF = 8'h20;
    localparam logic [7:0] REG_EN_OFF = 8'h24;
    localparam logic [7:0] VALID_OFF = 8'h28;
    localparam logic [7:0] FLAG_SEL_OFF = 8'h2c;
    localparam logic [7:0] CH_EN_OFF = 8'h30;
    // control bit positions (write one to act)
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    // interrupt bits
    localparam int IRQ_RUN_BIT = 0;
    localparam int IRQ_IDLE_BIT = 1;
    localparam int IRQ_RETRY_BIT = 2;
    localparam int IRQ_FAULT_BIT = 3;
    localparam int IRQ_W = 4;
    // reset values and nonvolatile locations
    localparam logic [31:0] CFG_BASE_RST = 32'h0003f000;
    localparam logic [31:0] PROG_BASE = 32'h00000000;
    localparam logic [31:0] FLAG_SEL_RST = 32'h00000000;
    // button debounce time and derived cycles at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    // per-step sequencing timeout before retry in power-up, or before the next step in power-down
    localparam int STEP_TIMEOUT_US = 1000;
    localparam int STEP_TIMEOUT_CYC = STEP_TIMEOUT_US * CLK_MHZ;
    // operating states
    typedef enum logic [1:0] {ST_IDLE, ST_POWER_UP, ST_RUNNING, ST_POWER_DOWN} op_state_e;
    // threshold-relative channel class, ordered low to high
    typedef enum logic [2:0] {
        CH_OFF,
        CH_UNDER_VOLTAGE_LEVEL_TWO,
        CH_UNDER_VOLTAGE_LEVEL_ONE,
        CH_NOMINAL,
        CH_OVER_VOLTAGE_LEVEL_ONE,
        CH_OVER_VOLTAGE_LEVEL_TWO
    } ch_class_e;
    // thresholds of one channel from the monitor engine
    typedef struct packed {
        logic [11:0] off_lvl;
        logic [11:0] uv2;
        logic [11:0] uv1;
        logic [11:0] ov1;
        logic [11:0] ov2;
        logic [11:0] hyst;
        logic [11:0] range_max;
    } ch_thr_s;
endpackage

// ### bench/reg_model.sv
// regulator and channel monitor model for the power sequence manager
`timescale 1ns/10ps
module reg_model #(
    parameter int NUM_CH = 22
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [31:0] regulator_enables,
    input wire logic [NUM_CH-1:0] stuck,
    input wire logic [NUM_CH-1:0] bad,
    input wire logic [11:0] test_code,
    input wire logic [3:0] lag,
    output logic [NUM_CH*12-1:0] ch_voltage,
    output psm_pkg::ch_thr_s [NUM_CH-1:0] ch_thr
);
    logic [3:0] ramp_q [NUM_CH];

    // ramp counter per regulator, so settling can be prompt or slow
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!nrst || !regulator_enables[i])
                ramp_q[i] <= 4'h0;
            else if (ramp_q[i] != 4'hf)
                ramp_q[i] <= ramp_q[i] + 4'h1;
        end
    end

    // output falls to zero at once when disabled; a stuck one sits in uv1
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!regulator_enables[i])
                ch_voltage[i*12+:12] = 12'h000;
            else if (ramp_q[i] < lag)
                ch_voltage[i*12+:12] = 12'h12c;
            else if (stuck[i])
                ch_voltage[i*12+:12] = 12'h1f4;
            else
                ch_voltage[i*12+:12] = (i < 2) ? test_code : 12'h320;
            // a bad channel gets a range below its upper threshold
            ch_thr[i] = '{12'h064, 12'h190, 12'h258, 12'h3e8, 12'h4b0, 12'h00a,
                bad[i] ? 12'h3e8 : 12'hfa0};
        end
    end
endmodule

// ### bench/power_sequence_manager_tb.sv
// self-checking bench of the power sequence manager over apb
`timescale 1ns/10ps
module power_sequence_manager_tb;
    localparam int NCH = 22;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic btn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] gp = 32'h0;
    logic [31:0] prdata, regen, flags, cfga, proga;
    logic pready, pslverr, olt, clt, mon, irq;
    logic [NCH*12-1:0] volt;
    psm_pkg::ch_thr_s [NCH-1:0] thr;
    logic [NCH-1:0] stuck = '0;
    logic [NCH-1:0] bad = '0;
    logic [11:0] code = 12'h320;
    logic [3:0] lag = 4'h1;
    logic [63:0] exp_q [$];
    logic [63:0] note;
    logic [11:0] codes [6] = '{12'h032, 12'h12c, 12'h1f4, 12'h320, 12'h44c, 12'h514};
    int error_cnt = 0;
    int cmp_count = 0;

    power_sequence_manager #(.NUM_CH(NCH), .DEBOUNCE_CYC(4), .STEP_TIMEOUT_CYC(50))
        power_sequence_manager_inst (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sequence_toggle_button(btn), .gp_inputs(gp), .ch_voltage(volt), .ch_thr(thr),
        .regulator_enables(regen), .output_flags(flags), .open_loop_trim_en(olt),
        .closed_loop_trim_en(clt), .monitor_en(mon), .cfg_fetch_addr(cfga),
        .prog_fetch_addr(proga), .irq(irq));
    reg_model #(.NUM_CH(NCH)) reg_model_inst (.clk_sys(clk_sys), .nrst(nrst),
        .regulator_enables(regen), .stuck(stuck), .bad(bad), .test_code(code),
        .lag(lag), .ch_voltage(volt), .ch_thr(thr));

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; returns at the edge that completes it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        exp_q.push_back({m, exp & m});
        apb(1'b0, a, 32'h0);
    endtask

    // read data taken at the completing edge, compared with the oldest note
    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            check(prdata & note[63:32], note[31:0]);
        end
    end

    // polls the trim/monitor levels; enables must stay a contiguous run
    task automatic wait_for(input logic up);
        int n;
        logic [21:0] x;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            x = up ? regen[21:0] : ~regen[21:0];
            check({10'h0, x & (x + 22'h1)}, 32'h0);
            n++;
        end
        while (((up ? clt : ~mon) !== 1'b1) && n < 5000);
        if (n >= 5000)
            error_cnt++;
    endtask

    task automatic wrap_up();
        repeat (3) @(posedge clk_sys);
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog, well beyond the expected run length
    initial
    begin
        #480000;
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(83));
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        check(cfga, 32'h0003f000);
        check(proga, 32'h0);
        check({29'h0, olt, clt, mon}, 32'h0);
        apb(1'b1, psm_pkg::CTRL_OFF, 32'h2);
        rd(psm_pkg::STATUS_OFF, 32'h0, 32'h3);
        rd(psm_pkg::CFG_BASE_OFF, 32'h0003f000, 32'hffffffff);
        rd(psm_pkg::REG_EN_OFF, 32'h0, 32'hffffffff);
        rd(psm_pkg::FLAGS_OFF, 32'h0, 32'hffffffff);
        rd(psm_pkg::CH_EN_OFF, 32'hffffffff, 32'hffffffff);
        rd(psm_pkg::FLAG_SEL_OFF, 32'h0, 32'hffffffff);
        rd(8'h3c, 32'h0, 32'hffffffff);
        $display("test reset values done");
        // power-up through control register, random settling time
        lag <= 4'($urandom_range(7, 1));
        apb(1'b1, psm_pkg::IRQ_MASK_OFF, 32'hf);
        apb(1'b1, psm_pkg::CTRL_OFF, 32'h1);
        repeat (2) @(posedge clk_sys);
        #1;
        check({29'h0, olt, clt, mon}, 32'h5);
        rd(psm_pkg::STATUS_OFF, 32'h1, 32'h3);
        wait_for(1'b1);
        check({30'h0, clt, mon}, 32'h3);
        rd(psm_pkg::STATUS_OFF, 32'h2, 32'h3);
        rd(psm_pkg::REG_EN_OFF, 32'h003fffff, 32'h003fffff);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        rd(psm_pkg::IRQ_STAT_OFF, 32'h1, 32'h1);
        apb(1'b1, psm_pkg::IRQ_STAT_OFF, 32'hf);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, psm_pkg::CTRL_OFF, 32'h1);
        rd(psm_pkg::STATUS_OFF, 32'h2, 32'h3);
        $display("test power-up done");
        // every class band, driven on channels 0 and 1 and read back on channel 1
        apb(1'b1, psm_pkg::CH_SEL_OFF, 32'h1);
        for (int k = 0; k < 6; k++)
        begin
            code <= codes[k];
            repeat (3) @(posedge clk_sys);
            rd(psm_pkg::CH_READ_OFF, {13'h0, 3'(k), 4'h0, codes[k]}, 32'h00070fff);
        end
        code <= 12'h320;
        gp <= $urandom;
        apb(1'b1, psm_pkg::FLAG_SEL_OFF, 32'hffffffff);
        repeat (4) @(posedge clk_sys);
        rd(psm_pkg::INPUTS_OFF, gp, 32'hffffffff);
        rd(psm_pkg::FLAGS_OFF, gp, 32'hffffffff);
        $display("test classes and flags done");
        // power-down by the button
        apb(1'b1, psm_pkg::IRQ_STAT_OFF, 32'hf);
        btn <= 1'b1;
        for (int n = 0; n < 40 && clt !== 1'b0; n++)
            @(posedge clk_sys);
        #1;
        check({30'h0, clt, mon}, 32'h1);
        rd(psm_pkg::STATUS_OFF, 32'h3, 32'h3);
        wait_for(1'b0);
        btn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check({29'h0, olt, clt, mon}, 32'h0);
        rd(psm_pkg::STATUS_OFF, 32'h0, 32'h3);
        rd(psm_pkg::REG_EN_OFF, 32'h0, 32'hffffffff);
        rd(psm_pkg::FLAGS_OFF, 32'h0, 32'hffffffff);
        rd(psm_pkg::IRQ_STAT_OFF, 32'h2, 32'h2);
        rd(psm_pkg::CH_READ_OFF, 32'h0, 32'h00070fff);
        bad[21] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(psm_pkg::VALID_OFF, 32'h00100000, 32'h00300000);
        bad <= '0;
        $display("test power-down done");
        // a stuck regulator forces a retry, then start and stop again
        apb(1'b1, psm_pkg::IRQ_STAT_OFF, 32'hf);
        stuck[5] <= 1'b1;
        btn <= 1'b1;
        // let the clear land before irq is polled again
        repeat (2) @(posedge clk_sys);
        for (int n = 0; n < 3000 && irq !== 1'b1; n++)
            @(posedge clk_sys);
        rd(psm_pkg::IRQ_STAT_OFF, 32'h4, 32'h4);
        rd(psm_pkg::STATUS_OFF, 32'h1, 32'h3);
        stuck <= '0;
        btn <= 1'b0;
        wait_for(1'b1);
        rd(psm_pkg::STATUS_OFF, 32'h2, 32'h3);
        apb(1'b1, psm_pkg::CTRL_OFF, 32'h2);
        wait_for(1'b0);
        rd(psm_pkg::STATUS_OFF, 32'h0, 32'h3);
        $display("test retry done");
        wrap_up();
    end
endmodule
